// file: design/panel_ctl_regs.svh
// Constants for the operator panel run-control block.
// Assumes inclusion by the package and the run-control modules.
`ifndef PANEL_CTL_REGS_SVH
`define PANEL_CTL_REGS_SVH
`define WORD_W            18
`define ADDR_W            13
`define LEVELS            3
`define NUMGEN_READ_ADDR  13'h1C03
`define IO_FUNC_CODE      4'hF
`define START_JUMP_LO     13'h1FF5
`define LOADER_FIRST      13'h1FF4
`define LOADER_LAST       13'h1FFF
`define LOADER_REL0       13'h1C00
`define LOADER_REL1       13'h1C08
`define AUTO_START_ADDR   13'h1FF1
`define AUTO_CONST        18'h2AAAA
`define DEBOUNCE_NS       2000000
`define CLK_PERIOD_NS     40
`define DEBOUNCE_CYC      ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MON_POSITIONS     11
`endif

// file: design/panel_ctl_pkg.sv
// Types for the operator panel run-control block.
// Assumes panel_ctl_regs.svh is on the include path.
`include "panel_ctl_regs.svh"
package panel_ctl_pkg;
  typedef enum logic [2:0] {
    KEY_AUTO   = 3'h1,
    KEY_MANUAL = 3'h2,
    KEY_TEST   = 3'h4
  } key_pos_t;

  typedef enum logic [1:0] {
    SW3_CENTRE = 2'h0,
    SW3_UP     = 2'h1,
    SW3_DOWN   = 2'h2
  } sw3_t;

  typedef enum logic [5:0] {
    ST_RESET   = 6'h01,
    ST_RUN     = 6'h02,
    ST_STOPPING= 6'h04,
    ST_STOPPED = 6'h08,
    ST_STEP    = 6'h10,
    ST_PARHALT = 6'h20
  } run_state_t;

  typedef struct packed {
    logic                  start_jump_up;
    logic                  start_jump_dn;
    logic                  stop;
    logic                  restart;
    logic                  reset;
    logic [`LEVELS-1:0]    int_btn;
  } panel_evt_t;

  typedef struct packed {
    logic                  go;
    logic [`ADDR_W-1:0]    go_addr;
    logic                  go_level1;
    logic                  clear_h;
    logic                  step_instr;
    logic                  step_micro;
    logic                  repeat_micro;
    logic                  enter_word;
    logic                  execute_word;
    logic                  cpu_reset;
  } cpu_cmd_t;
endpackage

// file: design/panel_sync.sv
// Two-flop synchroniser and debouncer for one panel contact.
// Assumes a raw mechanical contact, asynchronous to mclk_i.
`timescale 1ns/10ps
`include "panel_ctl_regs.svh"
module panel_sync #(
  parameter int unsigned DEB_CYC = `DEBOUNCE_CYC
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic raw_i,
  output logic      level_o,
  output logic      press_o
);
  import panel_ctl_pkg::*;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [31:0] cnt;
    logic        level;
    logic        press;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Level must hold steady for DEB_CYC before it is accepted
  always_comb begin
    st_nxt       = st_r;
    st_nxt.s1    = raw_i;
    st_nxt.s2    = st_r.s1;
    st_nxt.press = 1'b0;
    if (st_r.s2 == st_r.level) begin
      st_nxt.cnt = 32'h0;
    end else if (st_r.cnt >= DEB_CYC - 1) begin
      st_nxt.cnt   = 32'h0;
      st_nxt.level = st_r.s2;
      st_nxt.press = st_r.s2;   // One pulse per accepted press
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;
  assign press_o = st_r.press;
endmodule

// file: design/panel_run_ctl.sv
// Run-control and monitor logic behind the operator panel.
// Assumes raw panel contacts on pins and processor handshakes on mclk_i.
`timescale 1ns/10ps
`include "panel_ctl_regs.svh"
module panel_run_ctl #(
  parameter int unsigned DEB_CYC = `DEBOUNCE_CYC
) (
  input  wire logic                        mclk_i,
  input  wire logic                        reset_i,
  input  wire logic                        power_ok_i,
  input  wire panel_ctl_pkg::key_pos_t     key_i,
  input  wire logic [`WORD_W-1:0]          word_sw_i,
  input  wire logic                        jump_up_i,
  input  wire logic                        jump_dn_i,
  input  wire logic                        stop_btn_i,
  input  wire logic                        restart_btn_i,
  input  wire logic                        reset_btn_i,
  input  wire logic [2*`LEVELS-1:0]        level_key_i,
  input  wire logic [`LEVELS-1:0]          int_btn_i,
  input  wire panel_ctl_pkg::sw3_t         entry_sw_i,
  input  wire panel_ctl_pkg::sw3_t         exec_sw_i,
  input  wire panel_ctl_pkg::sw3_t         step_mode_i,
  input  wire logic                        micro_rep_i,
  input  wire logic                        lockout_i,
  input  wire logic                        parity_btn_i,
  input  wire logic [3:0]                  mon_sel_i,
  input  wire logic [`WORD_W*`MON_POSITIONS-1:0] mon_groups_i,
  input  wire logic                        instr_done_i,
  input  wire logic                        parity_err_i,
  input  wire logic                        io_in_i,
  input  wire logic                        io_out_i,
  input  wire logic [3:0]                  io_func_i,
  input  wire logic [`ADDR_W-1:0]          io_addr_i,
  input  wire logic [`LEVELS-1:0]          ext_int_i,
  input  wire logic [`LEVELS:0]            level_active_i,
  output logic [`WORD_W-1:0]               acc_in_o,
  output logic                             acc_in_vld_o,
  output panel_ctl_pkg::cpu_cmd_t          cmd_o,
  output logic                             run_o,
  output logic [`LEVELS-1:0]               int_req_o,
  output logic                             protect_o,
  output logic                             loader_map_o,
  output logic                             reset_lamp_o,
  output logic                             stop_lamp_o,
  output logic                             parity_en_lamp_o,
  output logic                             parity_lamp_o,
  output logic [`LEVELS-1:0]               red_lamp_o,
  output logic [`LEVELS-1:0]               green_lamp_o,
  output logic [`WORD_W-1:0]               mon_lamp_o
);
  import panel_ctl_pkg::*;

  localparam int NSW = 5 + `LEVELS;

  typedef struct packed {
    run_state_t         state;
    logic               por_done;
    logic               par_en;
    logic [`LEVELS-1:0] btn_pend;
    logic [`LEVELS-1:0] red;
    logic [`LEVELS-1:0] green;
    logic [`WORD_W-1:0] acc;
    logic               acc_vld;
    cpu_cmd_t           cmd;
    logic               run;
    logic [`LEVELS-1:0] int_req;
    logic               protect;
    logic               loader;
    logic               reset_lamp;
    logic               stop_lamp;
    logic               parity_lamp;
    logic [`WORD_W-1:0] mon;
    logic               pwr_s1;
    logic               pwr_s2;
    logic [2:0]         key_s1;
    logic [2:0]         key_s2;
    logic [`WORD_W-1:0] ws_s1;
    logic [`WORD_W-1:0] ws_s2;
    logic [2*`LEVELS-1:0] lk_s1;
    logic [2*`LEVELS-1:0] lk_s2;
    logic [9:0]         t_s1;
    logic [9:0]         t_s2;
    logic [`LEVELS-1:0] ext_s1;
    logic [`LEVELS-1:0] ext_s2;
    logic [4:0]         mon_s1;
    logic [4:0]         mon_s2;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  logic [NSW-1:0] raw_w;
  logic [NSW-1:0] prs_w;
  panel_evt_t     evt_w;

  // Debounced contacts: jump up/down, stop, restart, reset, level buttons
  assign raw_w = {jump_up_i, jump_dn_i, stop_btn_i, restart_btn_i, reset_btn_i, int_btn_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++) begin : g_sync
      panel_sync #(.DEB_CYC(DEB_CYC)) u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .raw_i   (raw_w[gi]),
        .level_o (),
        .press_o (prs_w[gi])
      );
    end
  endgenerate

  assign evt_w = panel_evt_t'(prs_w);

  always_comb begin
    logic                manual_ok;
    logic                test_ok;
    logic                entry_on;
    logic                exec_on;
    logic [1:0]          stepm;
    logic [1:0]          ent;
    logic [1:0]          exe;
    logic                mrep;
    logic                lock;
    logic                pbtn;
    logic [`LEVELS-1:0]  lvl_manual;
    logic [`LEVELS-1:0]  lvl_perm;
    logic                resume;
    // Panel qualifiers first, so every local has a value before any use
    manual_ok = (st_r.key_s2 != KEY_AUTO);
    test_ok   = (st_r.key_s2 == KEY_TEST);
    ent   = test_ok ? st_r.t_s2[9:8] : 2'h0;
    exe   = test_ok ? st_r.t_s2[7:6] : 2'h0;
    stepm = test_ok ? st_r.t_s2[5:4] : 2'h0;
    mrep  = test_ok & st_r.t_s2[3];
    lock  = test_ok & st_r.t_s2[2];
    pbtn  = test_ok & st_r.t_s2[1];
    entry_on = (ent != 2'h0);
    exec_on  = (exe != 2'h0);
    for (int i = 0; i < `LEVELS; i++) begin
      lvl_manual[i] = manual_ok & st_r.lk_s2[2*i+1];
      lvl_perm[i]   = manual_ok & st_r.lk_s2[2*i];
    end
    resume = manual_ok & evt_w.restart;
    st_nxt = st_r;
    // Level inputs from pins pass two flops first
    st_nxt.pwr_s1 = power_ok_i;
    st_nxt.pwr_s2 = st_r.pwr_s1;
    st_nxt.key_s1 = key_i;
    st_nxt.key_s2 = st_r.key_s1;
    st_nxt.ws_s1  = word_sw_i;
    st_nxt.ws_s2  = st_r.ws_s1;
    st_nxt.lk_s1  = level_key_i;
    st_nxt.lk_s2  = st_r.lk_s1;
    st_nxt.t_s1   = {entry_sw_i, exec_sw_i, step_mode_i, micro_rep_i, lockout_i, parity_btn_i,
                     1'b0};
    st_nxt.t_s2   = st_r.t_s1;
    st_nxt.ext_s1 = ext_int_i;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.mon_s1 = {1'b0, mon_sel_i};
    st_nxt.mon_s2 = st_r.mon_s1;

    // Defaults for one-cycle commands
    st_nxt.cmd     = '0;
    st_nxt.acc_vld = 1'b0;
    st_nxt.protect = ~lock;
    st_nxt.par_en  = pbtn;

    // Power-on reset held until interlocks clear
    if (!st_r.pwr_s2) begin
      st_nxt.por_done      = 1'b0;
      st_nxt.state         = ST_RESET;
      st_nxt.cmd.cpu_reset = 1'b1;
      st_nxt.run           = 1'b0;
    end else if (!st_r.por_done) begin
      st_nxt.por_done = 1'b1;
      if (st_r.key_s2 == KEY_AUTO) begin
        st_nxt.state         = ST_RUN;
        st_nxt.cmd.go        = 1'b1;
        st_nxt.cmd.go_level1 = 1'b1;
        st_nxt.cmd.go_addr   = `AUTO_START_ADDR;
      end
    end else if (manual_ok && evt_w.reset) begin
      st_nxt.state         = ST_RESET;
      st_nxt.cmd.cpu_reset = 1'b1;
    end else if (manual_ok && (evt_w.start_jump_up || evt_w.start_jump_dn)) begin
      st_nxt.state         = ST_RUN;
      st_nxt.cmd.go        = 1'b1;
      st_nxt.cmd.go_level1 = 1'b1;
      st_nxt.cmd.clear_h   = 1'b1;
      st_nxt.cmd.go_addr   = evt_w.start_jump_up ? st_r.ws_s2[`ADDR_W-1:0] : `START_JUMP_LO;
      st_nxt.loader        = ~evt_w.start_jump_up;
    end else begin
      case (st_r.state)
        ST_RESET: begin
          if (resume && (entry_on || exec_on)) begin
            st_nxt.state = ST_STEP;
          end
        end
        ST_RUN: begin
          if (manual_ok && evt_w.stop) begin
            st_nxt.state = ST_STOPPING;
          end else if (st_r.par_en && parity_err_i) begin
            st_nxt.state = ST_PARHALT;
          end else if (stepm != 2'h0 || ent == 2'h1 || exe == 2'h1) begin
            st_nxt.state = ST_STOPPING;
          end
        end
        ST_STOPPING: begin
          if (instr_done_i) begin
            st_nxt.state = ST_STOPPED;
          end
        end
        ST_STOPPED, ST_PARHALT: begin
          if (resume) begin
            st_nxt.state = ST_STEP;
          end
        end
        ST_STEP: begin
          st_nxt.cmd.step_instr   = (stepm == 2'h2);
          st_nxt.cmd.step_micro   = (stepm == 2'h1);
          st_nxt.cmd.repeat_micro = mrep;
          st_nxt.cmd.execute_word = exec_on;
          st_nxt.cmd.enter_word   = entry_on;
          if (entry_on) begin
            st_nxt.acc     = st_r.ws_s2;
            st_nxt.acc_vld = 1'b1;
          end
          // Single or any step mode waits for the next restart
          if (stepm != 2'h0 || ent == 2'h1 || exe == 2'h1 ||
              (mrep && stepm == 2'h1)) begin
            st_nxt.state = ST_STOPPING;
          end else if (!entry_on && !exec_on && !mrep) begin
            st_nxt.state = ST_RUN;
          end
        end
        default: st_nxt.state = ST_RESET;
      endcase
    end
    st_nxt.run = (st_nxt.state == ST_RUN) || (st_nxt.state == ST_STEP);

    // Input instruction 15/7171 reads the word switches, or a fixed constant with the key at auto
    if (io_in_i && io_func_i == `IO_FUNC_CODE && io_addr_i == `NUMGEN_READ_ADDR) begin
      st_nxt.acc     = manual_ok ? st_r.ws_s2 : `AUTO_CONST;
      st_nxt.acc_vld = 1'b1;
    end
    // Loader area released by output code 7168 or 7176; a jump in the same cycle wins
    if (io_out_i && io_func_i == `IO_FUNC_CODE &&
        (io_addr_i == `LOADER_REL0 || io_addr_i == `LOADER_REL1) && !st_nxt.cmd.go) begin
      st_nxt.loader = 1'b0;
    end

    // Interrupts: panel button pending set wins over its consumption
    for (int i = 0; i < `LEVELS; i++) begin
      st_nxt.btn_pend[i] = 1'b0;
      if (lvl_manual[i] && evt_w.int_btn[i]) begin
        st_nxt.btn_pend[i] = 1'b1;
      end
      st_nxt.int_req[i] = st_r.btn_pend[i] | lvl_perm[i] |
                          (~lvl_manual[i] & st_r.ext_s2[i]);
      st_nxt.red[i]   = st_nxt.int_req[i];
      st_nxt.green[i] = level_active_i[i+1];
    end

    // Lamps are live in every key position
    st_nxt.reset_lamp  = (st_nxt.state == ST_RESET);
    st_nxt.stop_lamp   = (st_nxt.state == ST_STOPPED) || (st_nxt.state == ST_PARHALT) ||
                         (stepm != 2'h0);
    st_nxt.parity_lamp = (st_nxt.state == ST_PARHALT);
    // Selector beyond the last position shows zero
    st_nxt.mon = '0;
    for (int p = 0; p < `MON_POSITIONS; p++) begin
      if (st_r.mon_s2 == 5'(p + 1)) begin
        st_nxt.mon = mon_groups_i[p*`WORD_W +: `WORD_W];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r          <= '0;
      st_r.state    <= ST_RESET;
      st_r.protect  <= 1'b1;
      st_r.reset_lamp <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign acc_in_o         = st_r.acc;
  assign acc_in_vld_o     = st_r.acc_vld;
  assign cmd_o            = st_r.cmd;
  assign run_o            = st_r.run;
  assign int_req_o        = st_r.int_req;
  assign protect_o        = st_r.protect;
  assign loader_map_o     = st_r.loader;
  assign reset_lamp_o     = st_r.reset_lamp;
  assign stop_lamp_o      = st_r.stop_lamp;
  assign parity_en_lamp_o = st_r.par_en;
  assign parity_lamp_o    = st_r.parity_lamp;
  assign red_lamp_o       = st_r.red;
  assign green_lamp_o     = st_r.green;
  assign mon_lamp_o       = st_r.mon;
endmodule

// file: verif/panel_operator.sv
// Operator model: pushes the panel buttons the way a hand does, with contact chatter.
// Assumes the caller names a button by index and that mclk_i is the processor clock.
`timescale 1ns/10ps
module panel_operator #(
  parameter int unsigned HOLD = 8
) (
  input  wire logic mclk_i,
  output logic       jump_up_o,
  output logic       jump_dn_o,
  output logic       stop_o,
  output logic       restart_o,
  output logic       reset_o,
  output logic [2:0] int_btn_o
);
  logic [7:0] btn_r;

  // Index order matches the bench's button table
  assign {int_btn_o, reset_o, restart_o, stop_o, jump_dn_o, jump_up_o} = btn_r;
  initial btn_r = 8'h00;

  // Chatter on break only, make is one clean rise; chatter must never yield a second event
  task automatic press(input int idx);
    for (int k = 0; k < HOLD + 4; k++) begin
      @(negedge mclk_i);
      btn_r[idx] = (k < 2 || k >= HOLD + 2) ? k[0] : 1'b1;
    end
    @(negedge mclk_i);
    btn_r[idx] = 1'b0;
  endtask
endmodule

// file: verif/panel_run_ctl_chk.sv
// Checker for the panel run-control block, bound to its ports.
// Assumes a single processor clock domain with synchronous reset.
`timescale 1ns/10ps
`include "panel_ctl_regs.svh"
module panel_run_ctl_chk
  import panel_ctl_pkg::*;
#(
  parameter int unsigned DEB_CYC = 2
) (
  input wire logic                                 mclk_i,
  input wire logic                                 reset_i,
  input wire panel_ctl_pkg::key_pos_t              key_i,
  input wire panel_ctl_pkg::sw3_t                  step_mode_i,
  input wire logic                                 io_in_i,
  input wire logic                                 io_out_i,
  input wire logic [3:0]                           io_func_i,
  input wire logic [`ADDR_W-1:0]                   io_addr_i,
  input wire logic [`LEVELS:0]                     level_active_i,
  input wire logic [3:0]                           mon_sel_i,
  input wire logic [`WORD_W*`MON_POSITIONS-1:0]    mon_groups_i,
  input wire logic                                 acc_in_vld_o,
  input wire panel_ctl_pkg::cpu_cmd_t              cmd_o,
  input wire logic                                 loader_map_o,
  input wire logic                                 stop_lamp_o,
  input wire logic                                 parity_lamp_o,
  input wire logic [`LEVELS-1:0]                   green_lamp_o,
  input wire logic [`WORD_W-1:0]                   mon_lamp_o
);
  localparam int unsigned SAT = DEB_CYC + 8;
  int unsigned        auto_cnt_r;
  int unsigned        step_cnt_r;
  logic [`WORD_W-1:0] mon_exp;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Dwell counters; saturate so a long dwell never wraps
  always_ff @(posedge mclk_i) begin
    if (reset_i || key_i != KEY_AUTO) auto_cnt_r <= 0;
    else if (auto_cnt_r < SAT) auto_cnt_r <= auto_cnt_r + 1;
    if (reset_i || key_i != KEY_TEST || step_mode_i == SW3_CENTRE) step_cnt_r <= 0;
    else if (step_cnt_r < SAT) step_cnt_r <= step_cnt_r + 1;
  end

  // Selector positions 1 to 11; anything else shows dark lamps
  assign mon_exp = (mon_sel_i >= 4'h1 && mon_sel_i <= 4'hB) ?
                   mon_groups_i[(int'(mon_sel_i) - 1) * `WORD_W +: `WORD_W] : '0;

  property p_io_answer;
    io_in_i && io_func_i == `IO_FUNC_CODE && io_addr_i == `NUMGEN_READ_ADDR |=> acc_in_vld_o;
  endproperty
  a_io_answer: assert property (p_io_answer) else $error("switch read not answered");
  property p_io_cause;
    acc_in_vld_o && !cmd_o.enter_word |->
      $past(io_in_i) && $past(io_func_i) == `IO_FUNC_CODE &&
      $past(io_addr_i) == `NUMGEN_READ_ADDR;
  endproperty
  a_io_cause: assert property (p_io_cause) else $error("answer without a read");
  property p_go_pulse;
    cmd_o.go |=> !cmd_o.go;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("start command too long");
  property p_go_level;
    cmd_o.go |-> cmd_o.go_level1;
  endproperty
  a_go_level: assert property (p_go_level) else $error("start not on level one");
  property p_auto_locked;
    auto_cnt_r == SAT |-> !cmd_o.go || cmd_o.go_addr == `AUTO_START_ADDR;
  endproperty
  a_auto_locked: assert property (p_auto_locked) else $error("jump honoured in auto");
  property p_parity_test;
    $rose(parity_lamp_o) |-> key_i == KEY_TEST;
  endproperty
  a_parity_test: assert property (p_parity_test) else $error("parity halt outside test");
  property p_step_lamp;
    step_cnt_r == SAT |-> stop_lamp_o;
  endproperty
  a_step_lamp: assert property (p_step_lamp) else $error("stop lamp dark in step mode");
  property p_green;
    $stable(level_active_i) |-> ##[0:3] green_lamp_o == level_active_i[3:1];
  endproperty
  a_green: assert property (p_green) else $error("green lamps off the running level");
  property p_monitor;
    $stable(mon_sel_i) && $stable(mon_groups_i) |-> ##[0:4] mon_lamp_o == mon_exp;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor shows wrong group");
  property p_loader;
    loader_map_o && io_out_i && io_func_i == `IO_FUNC_CODE &&
    (io_addr_i == `LOADER_REL0 || io_addr_i == `LOADER_REL1) |-> ##[1:2] !loader_map_o;
  endproperty
  a_loader: assert property (p_loader) else $error("loader area not released");
endmodule

bind panel_run_ctl panel_run_ctl_chk #(.DEB_CYC(DEB_CYC)) u_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .key_i(key_i), .step_mode_i(step_mode_i),
  .io_in_i(io_in_i), .io_out_i(io_out_i), .io_func_i(io_func_i), .io_addr_i(io_addr_i),
  .level_active_i(level_active_i), .mon_sel_i(mon_sel_i), .mon_groups_i(mon_groups_i),
  .acc_in_vld_o(acc_in_vld_o), .cmd_o(cmd_o), .loader_map_o(loader_map_o),
  .stop_lamp_o(stop_lamp_o), .parity_lamp_o(parity_lamp_o), .green_lamp_o(green_lamp_o),
  .mon_lamp_o(mon_lamp_o));

// file: verif/testbench.sv
// Self-checking bench for the panel run-control block.
// Assumes panel_operator presses the buttons; processor handshakes are driven here.
`timescale 1ns/10ps
`include "panel_ctl_regs.svh"
module testbench;
  import panel_ctl_pkg::*;
  localparam int unsigned DEB = 2;
  localparam int BJU = 0, BJD = 1, BSTOP = 2, BRST = 3, BRSB = 4, BINT = 5;
  logic                              mclk_i = 1'b0, reset_i = 1'b1, power_ok_i = 1'b0;
  key_pos_t                          key_i = KEY_MANUAL;
  logic [`WORD_W-1:0]                word_sw_i = '0, acc_in_o, mon_lamp_o;
  logic                              jump_up_i, jump_dn_i, stop_btn_i, restart_btn_i;
  logic                              reset_btn_i, acc_in_vld_o, run_o, protect_o;
  logic [`LEVELS-1:0]                int_btn_i, int_req_o, red_lamp_o, green_lamp_o;
  logic [`LEVELS-1:0]                ext_int_i = '0;
  logic [2*`LEVELS-1:0]              level_key_i = '0;
  sw3_t                              entry_sw_i = SW3_CENTRE, exec_sw_i = SW3_CENTRE;
  sw3_t                              step_mode_i = SW3_CENTRE;
  logic                              micro_rep_i = 1'b0, lockout_i = 1'b0, parity_btn_i = 1'b0;
  logic [3:0]                        mon_sel_i = '0, io_func_i = `IO_FUNC_CODE;
  logic [`WORD_W*`MON_POSITIONS-1:0] mon_groups_i = '0;
  logic                              instr_done_i = 1'b0, parity_err_i = 1'b0;
  logic                              io_in_i = 1'b0, io_out_i = 1'b0;
  logic [`ADDR_W-1:0]                io_addr_i = '0;
  logic [`LEVELS:0]                  level_active_i = '0;
  logic                              loader_map_o, reset_lamp_o, stop_lamp_o;
  logic                              parity_en_lamp_o, parity_lamp_o;
  cpu_cmd_t                          cmd_o, last_go;
  int                                fail_count = 0, check_count = 0, go_count = 0;
  int                                irq_count = 0, step_count = 0;
  logic [`LEVELS-1:0]                red_seen = '0;

  panel_run_ctl #(.DEB_CYC(DEB)) DUT (
    .mclk_i, .reset_i, .power_ok_i, .key_i, .word_sw_i, .jump_up_i, .jump_dn_i, .stop_btn_i,
    .restart_btn_i, .reset_btn_i, .level_key_i, .int_btn_i, .entry_sw_i, .exec_sw_i,
    .step_mode_i, .micro_rep_i, .lockout_i, .parity_btn_i, .mon_sel_i, .mon_groups_i,
    .instr_done_i, .parity_err_i, .io_in_i, .io_out_i, .io_func_i, .io_addr_i, .ext_int_i,
    .level_active_i, .acc_in_o, .acc_in_vld_o, .cmd_o, .run_o, .int_req_o, .protect_o,
    .loader_map_o, .reset_lamp_o, .stop_lamp_o, .parity_en_lamp_o, .parity_lamp_o,
    .red_lamp_o, .green_lamp_o, .mon_lamp_o);
  panel_operator u_op (.mclk_i, .jump_up_o(jump_up_i), .jump_dn_o(jump_dn_i),
    .stop_o(stop_btn_i), .restart_o(restart_btn_i), .reset_o(reset_btn_i),
    .int_btn_o(int_btn_i));

  always #20 mclk_i = ~mclk_i;

  // Start commands stand one cycle, so the falling edge sees each exactly once
  always @(negedge mclk_i) begin
    if (cmd_o.go === 1'b1) begin
      go_count++;
      last_go = cmd_o;
    end
    // Pulses and one-cycle lamps are gathered here, since they are gone by check time
    step_count += int'(cmd_o.step_micro === 1'b1);
    irq_count += int'(int_req_o[0] === 1'b1);
    red_seen = red_seen | red_lamp_o;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // One I/O instruction, a cycle clear of the last; returns on the cycle the answer stands
  task automatic io_cyc(input logic rd, input logic [`ADDR_W-1:0] addr);
    cyc(1);
    io_in_i = rd;
    io_out_i = !rd;
    io_addr_i = addr;
    cyc(1);
    io_in_i = 1'b0;
    io_out_i = 1'b0;
  endtask
  task automatic push(input int b);
    go_count = 0;
    irq_count = 0;
    step_count = 0;
    red_seen = '0;
    u_op.press(b);
    cyc(DEB + 6);
  endtask
  task automatic done_pulse;
    instr_done_i = 1'b1;
    cyc(1);
    instr_done_i = 1'b0;
    cyc(3);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Runs far longer than the sequence needs, which is under two thousand cycles
  initial begin
    #(40 * 5000);
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test;
  end

  initial begin
    cyc(12);
    reset_i = 1'b0;
    cyc(2);
    check(reset_lamp_o, 1'b1);
    check(protect_o, 1'b1);
    power_ok_i = 1'b1;
    cyc(10);
    check(reset_lamp_o, 1'b1);
    check(go_count, 0);
    word_sw_i = 18'h25A5A;
    cyc(4);
    io_cyc(1'b1, `NUMGEN_READ_ADDR);
    check(acc_in_vld_o, 1'b1);
    check(acc_in_o, 18'h25A5A);
    io_cyc(1'b1, 13'h1C02);
    check(acc_in_vld_o, 1'b0);
    // Upper switch bits must not leak into the start address
    word_sw_i = 18'h3C123;
    cyc(4);
    push(BJU);
    check(go_count, 1);
    check({last_go.go_addr, last_go.go_level1, last_go.clear_h}, {13'h0123, 2'b11});
    check({reset_lamp_o, run_o}, 2'b01);
    level_active_i = 4'h2;
    cyc(4);
    check(green_lamp_o, 3'h1);
    push(BSTOP);
    check(stop_lamp_o, 1'b0);
    done_pulse;
    check({stop_lamp_o, run_o}, 2'b10);
    push(BRST);
    done_pulse;
    check({stop_lamp_o, run_o}, 2'b01);
    push(BJD);
    check({last_go.go_addr, last_go.clear_h}, {`START_JUMP_LO, 1'b1});
    check(loader_map_o, 1'b1);
    io_cyc(1'b0, `LOADER_REL0);
    cyc(3);
    check(loader_map_o, 1'b0);
    // Manual level ignores external demands but honours its button
    level_key_i = 6'h02;
    ext_int_i = 3'h1;
    cyc(6);
    check(int_req_o[0], 1'b0);
    ext_int_i = 3'h0;
    push(BINT);
    check(irq_count, 1);
    check(red_seen[0], 1'b1);
    level_key_i = 6'h04;
    cyc(6);
    check(int_req_o[1], 1'b1);
    level_key_i = 6'h00;
    ext_int_i = 3'h4;
    cyc(6);
    push(BINT + 1);
    check({int_req_o[1], red_seen[1], int_req_o[2]}, 3'b001);
    ext_int_i = 3'h0;
    key_i = KEY_AUTO;
    cyc(6);
    push(BJU);
    check(go_count, 0);
    io_cyc(1'b1, `NUMGEN_READ_ADDR);
    check(acc_in_o, `AUTO_CONST);
    level_key_i = 6'h02;
    ext_int_i = 3'h1;
    cyc(6);
    check(int_req_o[0], 1'b1);
    level_key_i = 6'h00;
    ext_int_i = 3'h0;
    key_i = KEY_MANUAL;
    parity_btn_i = 1'b1;
    cyc(6);
    parity_err_i = 1'b1;
    cyc(1);
    parity_err_i = 1'b0;
    cyc(4);
    check({parity_lamp_o, run_o}, 2'b01);
    key_i = KEY_TEST;
    cyc(6);
    check(parity_en_lamp_o, 1'b1);
    parity_err_i = 1'b1;
    cyc(1);
    parity_err_i = 1'b0;
    cyc(4);
    check({parity_lamp_o, run_o}, 2'b10);
    push(BRST);
    check({stop_lamp_o, run_o}, 2'b01);
    step_mode_i = SW3_UP;
    cyc(DEB + 10);
    check({stop_lamp_o, run_o}, 2'b10);
    done_pulse;
    push(BRST);
    check(step_count, 1);
    step_mode_i = SW3_CENTRE;
    entry_sw_i = SW3_UP;
    word_sw_i = 18'h1B2C3;
    cyc(6);
    done_pulse;
    push(BRST);
    check(acc_in_o, 18'h1B2C3);
    entry_sw_i = SW3_CENTRE;
    // Monitor groups in every key position
    for (int p = 0; p < `MON_POSITIONS; p++)
      mon_groups_i[p * `WORD_W +: `WORD_W] = 18'(32'h20001 + p * 32'h1111);
    for (int k = 0; k < 3; k++) begin
      key_i = key_pos_t'(3'h1 << k);
      for (int s = 1; s <= `MON_POSITIONS; s++) begin
        mon_sel_i = 4'(s);
        cyc(6);
        check(mon_lamp_o, 18'(32'h20001 + (s - 1) * 32'h1111));
      end
    end
    key_i = KEY_MANUAL;
    cyc(6);
    push(BRSB);
    check(reset_lamp_o, 1'b1);
    finish_test;
  end
endmodule
